/* rtl/cst_pkg.sv */
package cst_pkg;

    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [7:0] CST_HPOS_OFS     = 8'h00;
    localparam logic [7:0] CST_HLEN_OFS     = 8'h04;
    localparam logic [7:0] CST_HSEND_OFS    = 8'h08;
    localparam logic [7:0] CST_HBRISE_OFS   = 8'h0c;
    localparam logic [7:0] CST_HBFALL_OFS   = 8'h10;
    localparam logic [7:0] CST_HPRE_OFS     = 8'h14;
    localparam logic [7:0] CST_VPOS_OFS     = 8'h18;
    localparam logic [7:0] CST_VLEN_OFS     = 8'h1c;
    localparam logic [7:0] CST_VSEND_OFS    = 8'h20;
    localparam logic [7:0] CST_VBRISE_OFS   = 8'h24;
    localparam logic [7:0] CST_VBFALL_OFS   = 8'h28;
    localparam logic [7:0] CST_VPRE_OFS     = 8'h2c;
    localparam logic [7:0] CST_SERIAL_OFS   = 8'h30;
    localparam logic [7:0] CST_CTRL_OFS     = 8'h34;

    localparam int         CST_CW           = 12;
    localparam logic [11:0] CST_CNT_RESET   = 12'h000;
    localparam logic [1:0]  CST_CTRL_RESET  = 2'h0;
    localparam int         CST_CTRL_VONLY   = 0;
    localparam int         CST_CTRL_RUN     = 1;

    // ****************************************
    // Carrier types
    // ****************************************
    typedef struct packed {
        logic hsync_n;
        logic vsync_n;
        logic hblank_n;
        logic vblank_n;
    } cst_video_type;

    typedef struct packed {
        logic hsync_n;
        logic vsync_n;
    } cst_ext_sync_type;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } cst_apb_req_type;

endpackage : cst_pkg

/* rtl/cst_timing.sv */
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
// How it works
// - Read-only 12-bit horizontal counter steps on each timing clock from host value.
// - Horizontal counter equal to horizontal length means wrap.
// - Horizontal sync ends when horizontal count reaches sync end register.
// - Horizontal blank rises at the horizontal blank rise register position.
// - Horizontal blank falls at the horizontal blank fall register position.
// - Any horizontal sync or external vertical sync loads horizontal preload.
// - Read-only 12-bit vertical counter steps once per horizontal sync.
// - Vertical counter compared against vertical length minus one decides wrap.
// - Vertical sync ends when line count reaches vertical sync end register.
// - Vertical blank rises at the vertical blank rise register line.
// - Vertical blank falls at the vertical blank fall register line.
// - Any vertical sync loads vertical counter from vertical preload register.
// - Serial tracker clears after each read transfer, counts timing clocks.
// - Tracker mirrors half flag and triggers shift register loads.
// - Vertical counter runs from vertical preload to length minus one, then repeats.
// - External vertical-only mode preloads both counters on vsync fall.
module cst_timing
    import cst_pkg::*;
#(
    parameter int SERIAL_W = 9
)(
    input  wire logic               mclk,
    input  wire logic               reset,
    input  wire logic               crt_timing_clock,
    input  wire logic               read_transfer_done,
    input  wire logic               ext_hsync_n,
    input  wire logic               ext_vsync_n,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    output cst_video_type           video,
    output logic                    serial_half_flag,
    output logic                    shift_load_req
);

    initial
    begin
        if (SERIAL_W < 2 || SERIAL_W > 16)
            $error("SERIAL_W must be 2..16");
    end

    // ****************************************
    // Registers
    // ****************************************
    logic [11:0]         hpos;
    logic [11:0]         hlen;
    logic [11:0]         hsend;
    logic [11:0]         hbrise;
    logic [11:0]         hbfall;
    logic [11:0]         hpre;
    logic [11:0]         vpos;
    logic [11:0]         vlen;
    logic [11:0]         vsend;
    logic [11:0]         vbrise;
    logic [11:0]         vbfall;
    logic [11:0]         vpre;
    logic [1:0]          ctrl;
    logic [SERIAL_W-1:0] serial_count;
    logic                ext_h_d;
    logic                ext_v_d;
    logic                half_d;

    logic                apb_access;
    logic                apb_write;
    logic                ext_h_fall;
    logic                ext_v_fall;
    logic                run;
    logic                int_hsync;
    logic                int_vsync;
    logic                hsync_evt;
    logic                vsync_evt;
    logic                h_preload;
    logic                v_preload;
    logic [11:0]         next_hpos;
    logic [11:0]         next_vpos;
    logic [31:0]         next_prdata;
    logic                next_half;

    assign apb_access = psel && penable;
    assign apb_write  = apb_access && pwrite;
    assign run        = ctrl[CST_CTRL_RUN];

    // ****************************************
    // Sync events
    // ****************************************
    // Inputs are synchronous; fall seen as high-then-low.
    assign ext_h_fall = ext_h_d && !ext_hsync_n;
    assign ext_v_fall = ext_v_d && !ext_vsync_n;

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            ext_h_d <= 1'b1;
            ext_v_d <= 1'b1;
        end
        else
        begin
            ext_h_d <= ext_hsync_n;
            ext_v_d <= ext_vsync_n;
        end
    end

    // Internal sync starts when the line wraps (count equal to horizontal length)
    assign int_hsync = run && crt_timing_clock && (hpos == hlen);
    assign int_vsync = int_hsync && (vpos == vlen - 12'h001);
    // External hsync ignored in vertical-only mode
    assign hsync_evt = int_hsync || (ext_h_fall && !ctrl[CST_CTRL_VONLY]);
    assign vsync_evt = int_vsync || ext_v_fall;
    assign h_preload = hsync_evt || ext_v_fall;
    assign v_preload = vsync_evt;

    // ****************************************
    // Counters
    // ****************************************
    always_comb
    begin
        next_hpos = hpos;
        if (h_preload)
            next_hpos = hpre;
        else if (run && crt_timing_clock)
            next_hpos = hpos + 12'h001;
    end

    always_comb
    begin
        next_vpos = vpos;
        if (v_preload)
            next_vpos = vpre;
        else if (hsync_evt)
            next_vpos = vpos + 12'h001;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            hpos <= CST_CNT_RESET;
            vpos <= CST_CNT_RESET;
        end
        else
        begin
            hpos <= next_hpos;
            vpos <= next_vpos;
        end
    end

    // ****************************************
    // Sync and blank outputs
    // ****************************************
    // Edges set by equality so a mid-frame register write takes effect when the count next equals it.
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            video <= '{hsync_n: 1'b1, vsync_n: 1'b1, hblank_n: 1'b1, vblank_n: 1'b1};
        end
        else
        begin
            if (next_hpos == hsend)
                video.hsync_n <= 1'b1;
            else if (h_preload)
                video.hsync_n <= 1'b0;
            if (next_hpos == hbrise)
                video.hblank_n <= 1'b1;
            else if (next_hpos == hbfall)
                video.hblank_n <= 1'b0;
            if (next_vpos == vsend)
                video.vsync_n <= 1'b1;
            else if (v_preload)
                video.vsync_n <= 1'b0;
            if (next_vpos == vbrise)
                video.vblank_n <= 1'b1;
            else if (next_vpos == vbfall)
                video.vblank_n <= 1'b0;
        end
    end

    // ****************************************
    // Serial buffer tracker
    // ****************************************
    always_ff @(posedge mclk)
    begin
        if (reset)
            serial_count <= '0;
        else if (read_transfer_done)
            serial_count <= '0;
        else if (crt_timing_clock)
            serial_count <= serial_count + 1'b1;
    end

    // Top bit is the half flag; its rise asks for a split reload
    assign next_half = serial_count[SERIAL_W-1];

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            half_d           <= 1'b0;
            serial_half_flag <= 1'b0;
            shift_load_req   <= 1'b0;
        end
        else
        begin
            half_d           <= next_half;
            serial_half_flag <= next_half;
            shift_load_req   <= next_half && !half_d;
        end
    end

    // ****************************************
    // APB slave
    // ****************************************
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            hlen   <= CST_CNT_RESET;
            hsend  <= CST_CNT_RESET;
            hbrise <= CST_CNT_RESET;
            hbfall <= CST_CNT_RESET;
            hpre   <= CST_CNT_RESET;
            vlen   <= CST_CNT_RESET;
            vsend  <= CST_CNT_RESET;
            vbrise <= CST_CNT_RESET;
            vbfall <= CST_CNT_RESET;
            vpre   <= CST_CNT_RESET;
            ctrl   <= CST_CTRL_RESET;
        end
        else if (apb_write)
        begin
            unique case (paddr)
                CST_HLEN_OFS:   hlen   <= pwdata[11:0];
                CST_HSEND_OFS:  hsend  <= pwdata[11:0];
                CST_HBRISE_OFS: hbrise <= pwdata[11:0];
                CST_HBFALL_OFS: hbfall <= pwdata[11:0];
                CST_HPRE_OFS:   hpre   <= pwdata[11:0];
                CST_VLEN_OFS:   vlen   <= pwdata[11:0];
                CST_VSEND_OFS:  vsend  <= pwdata[11:0];
                CST_VBRISE_OFS: vbrise <= pwdata[11:0];
                CST_VBFALL_OFS: vbfall <= pwdata[11:0];
                CST_VPRE_OFS:   vpre   <= pwdata[11:0];
                CST_CTRL_OFS:   ctrl   <= pwdata[1:0];
                default:        ;
            endcase
        end
    end

    always_comb
    begin
        next_prdata = 32'h0000_0000;
        unique case (paddr)
            CST_HPOS_OFS:   next_prdata[11:0] = hpos;
            CST_HLEN_OFS:   next_prdata[11:0] = hlen;
            CST_HSEND_OFS:  next_prdata[11:0] = hsend;
            CST_HBRISE_OFS: next_prdata[11:0] = hbrise;
            CST_HBFALL_OFS: next_prdata[11:0] = hbfall;
            CST_HPRE_OFS:   next_prdata[11:0] = hpre;
            CST_VPOS_OFS:   next_prdata[11:0] = vpos;
            CST_VLEN_OFS:   next_prdata[11:0] = vlen;
            CST_VSEND_OFS:  next_prdata[11:0] = vsend;
            CST_VBRISE_OFS: next_prdata[11:0] = vbrise;
            CST_VBFALL_OFS: next_prdata[11:0] = vbfall;
            CST_VPRE_OFS:   next_prdata[11:0] = vpre;
            CST_SERIAL_OFS: next_prdata[SERIAL_W-1:0] = serial_count;
            CST_CTRL_OFS:   next_prdata[1:0] = ctrl;
            default:        next_prdata = 32'h0000_0000;
        endcase
    end

    // Registered answer: pready in the first cycle of the access phase
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && (paddr > CST_CTRL_OFS || paddr[1:0] != 2'h0);
            prdata  <= next_prdata;
        end
    end

endmodule : cst_timing

/* tb/cst_timing_props.sv */
`timescale 1ns/1ps
module cst_timing_props
    import cst_pkg::*;
#(
    parameter int SERIAL_W = 9
)(
    input wire logic          mclk,
    input wire logic          reset,
    input wire logic          crt_timing_clock,
    input wire logic          read_transfer_done,
    input wire logic          ext_hsync_n,
    input wire logic          ext_vsync_n,
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pwrite,
    input wire logic [7:0]    paddr,
    input wire logic [31:0]   pwdata,
    input wire logic [31:0]   prdata,
    input wire logic          pready,
    input wire logic          pslverr,
    input wire cst_video_type video,
    input wire logic          serial_half_flag,
    input wire logic          shift_load_req
);
    // ****
    // Checks
    // ****
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    // External preloads may move outputs a few edges late
    logic [3:0] ext_hist;
    always_ff @(posedge mclk)
        ext_hist <= {ext_hist[2:0], ext_hsync_n & ext_vsync_n};
    wire quiet = &ext_hist;

    AST_RDY_SETUP: assert property (psel && !penable |=> pready && penable)
        else $error("no ready after setup");
    AST_RDY_ONE: assert property (pready |=> !pready)
        else $error("ready held too long");
    AST_UNMAPPED: assert property (psel && !penable && paddr > 8'h34 |=> pslverr)
        else $error("unmapped access not refused");
    AST_UPPER: assert property (pready && !pwrite |-> prdata[31:12] == 20'h0)
        else $error("upper read bits set");
    // Flag is one register behind the tracker, so look two edges on
    AST_CLR: assert property (read_transfer_done |-> ##2 !serial_half_flag)
        else $error("tracker not cleared");
    AST_LOAD: assert property ($rose(serial_half_flag) |-> ##[0:1] shift_load_req)
        else $error("no load request");
    AST_PULSE: assert property (shift_load_req |=> !shift_load_req)
        else $error("load request too long");
    AST_HFALL: assert property ($fell(video.hsync_n) && quiet |-> $past(crt_timing_clock))
        else $error("line sync without tick");
    AST_VFALL: assert property ($fell(video.vsync_n) && quiet |-> !video.hsync_n)
        else $error("frame sync off a line start");
    // A register write may move an edge onto the idle count one edge later
    AST_HOLD: assert property (!$past(crt_timing_clock) && quiet && !$past(psel && penable && pwrite, 2) |-> $stable(video))
        else $error("video moved without tick");

    cover property ($fell(video.vsync_n));
    cover property (pslverr);
    cover property (shift_load_req);
endmodule : cst_timing_props

bind cst_timing cst_timing_props #(.SERIAL_W(SERIAL_W)) cst_timing_props_i (.*);

/* tb/cst_monitor.sv */
`timescale 1ns/1ps
module cst_monitor
    import cst_pkg::*;
(
    input  wire logic          mclk,
    input  wire logic          reset,
    input  wire logic          crt_timing_clock,
    input  wire cst_video_type video,
    output logic [11:0]        len,
    output logic [11:0]        send,
    output logic [11:0]        brise,
    output logic [11:0]        bfall,
    output logic [11:0]        frame,
    output logic [11:0]        vbr,
    output logic [11:0]        vbf
);
    // ****
    // Receiver side positions
    // ****
    logic [11:0] tcnt;
    logic [11:0] lines;
    logic [3:0]  pv;
    // Edges seen one edge late, so tcnt equals the line position
    always_ff @(posedge mclk)
    begin
        pv <= video;
        if (reset)
        begin
            tcnt <= 12'h000;
            lines <= 12'h000;
        end
        else if (pv[3] && !video.hsync_n)
        begin
            len <= tcnt;
            tcnt <= 12'h000;
            lines <= lines + 12'h001;
            if (pv[2] && !video.vsync_n)
            begin
                frame <= lines;
                lines <= 12'h001;
            end
        end
        else if (crt_timing_clock)
            tcnt <= tcnt + 12'h001;
        if (!pv[3] && video.hsync_n)
            send <= tcnt;
        if (!pv[1] && video.hblank_n)
            brise <= tcnt;
        if (pv[1] && !video.hblank_n)
            bfall <= tcnt;
        if (!pv[0] && video.vblank_n)
            vbr <= lines;
        if (pv[0] && !video.vblank_n)
            vbf <= lines;
    end
endmodule : cst_monitor

/* tb/cst_timing_tb.sv */
`timescale 1ns/1ps
module cst_timing_tb;
    import cst_pkg::*;
    logic mclk, reset = 1'b1, crt_timing_clock = 1'b0, read_transfer_done = 1'b0;
    logic ext_hsync_n = 1'b1, ext_vsync_n = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, serial_half_flag, shift_load_req, er;
    cst_video_type video;
    logic [11:0] len, send, brise, bfall, frame, vbr, vbf;
    int fail_count = 0, total_checks = 0, loads = 0, l0;

    cst_timing #(.SERIAL_W(3)) cst_timing_i (.*);
    cst_monitor cst_monitor_i (.*);

    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk)
        if (shift_load_req === 1'b1)
            loads <= loads + 1;

    // ****
    // Shared tasks
    // ****
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (n >= 16)
        begin
            fail_count++;
            print_verdict();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic ticks(input int n);
        repeat (n)
        begin
            @(posedge mclk);
            crt_timing_clock <= 1'b1;
            @(posedge mclk);
            crt_timing_clock <= 1'b0;
        end
    endtask : ticks

    task automatic ext(input logic h, input logic [11:0] hp, input logic [11:0] vp);
        @(posedge mclk);
        ext_hsync_n <= !h;
        ext_vsync_n <= h;
        @(posedge mclk);
        ext_hsync_n <= 1'b1;
        ext_vsync_n <= 1'b1;
        repeat (4) @(posedge mclk);
        apb(1'b0, CST_HPOS_OFS, 32'h0);
        chk(rd, 32'(hp));
        apb(1'b0, CST_VPOS_OFS, 32'h0);
        chk(rd, 32'(vp));
    endtask : ext

    // ****
    // Scenarios
    // ****
    task automatic t_regs;
        for (int i = 1; i < 12; i++)
        begin
            apb(1'b0, 8'(i * 4), 32'h0);
            chk(rd, 32'h0);
            apb(1'b1, 8'(i * 4), 32'hfffff000 | 32'(i * 3 + 16));
            apb(1'b0, 8'(i * 4), 32'h0);
            chk(rd, (i == 6) ? 32'h0 : 32'(i * 3 + 16));
        end
        apb(1'b1, 8'h38, 32'h1);
        chk({31'h0, er}, 32'h1);
        apb(1'b0, 8'h38, 32'h0);
        chk({rd[30:0], er}, 32'h1);
        $display("test regs done");
    endtask : t_regs

    task automatic t_timing;
        logic [11:0] cfg [12] = '{0, 9, 2, 4, 7, 0, 0, 6, 2, 3, 4, 0};
        for (int i = 1; i < 12; i++)
            apb(1'b1, 8'(i * 4), 32'(cfg[i]));
        apb(1'b1, CST_CTRL_OFS, 32'h2);
        ticks(200);
        chk(32'(len), 32'd10);
        chk(32'(send), 32'd2);
        chk(32'(brise), 32'd4);
        chk(32'(bfall), 32'd7);
        chk(32'(frame), 32'd6);
        chk(32'(vbr), 32'd3);
        chk(32'(vbf), 32'd4);
        apb(1'b1, CST_HPRE_OFS, 32'h1);
        apb(1'b1, CST_VPRE_OFS, 32'h1);
        ticks(200);
        chk(32'(len), 32'd9);
        chk(32'(frame), 32'd5);
        $display("test timing done");
    endtask : t_timing

    task automatic t_preload;
        // Frame sync first, so the line count is known before a line sync
        apb(1'b1, CST_HPRE_OFS, 32'h5);
        apb(1'b1, CST_VPRE_OFS, 32'h3);
        ext(1'b0, 12'h5, 12'h3);
        apb(1'b1, CST_HPRE_OFS, 32'h7);
        ext(1'b1, 12'h7, 12'h4);
        apb(1'b1, CST_CTRL_OFS, 32'h3);
        apb(1'b1, CST_HPRE_OFS, 32'h2);
        apb(1'b1, CST_VPRE_OFS, 32'h4);
        ext(1'b0, 12'h2, 12'h4);
        // Line sync is ignored in frame-only mode
        ext(1'b1, 12'h2, 12'h4);
        $display("test preload done");
    endtask : t_preload

    task automatic t_serial;
        @(posedge mclk);
        read_transfer_done <= 1'b1;
        crt_timing_clock <= 1'b1;
        @(posedge mclk);
        read_transfer_done <= 1'b0;
        crt_timing_clock <= 1'b0;
        apb(1'b0, CST_SERIAL_OFS, 32'h0);
        chk(rd, 32'h0);
        l0 = loads;
        ticks(4);
        repeat (3) @(posedge mclk);
        chk(32'(serial_half_flag), 32'h1);
        chk(32'(loads - l0), 32'h1);
        apb(1'b0, CST_SERIAL_OFS, 32'h0);
        chk(rd, 32'h4);
        $display("test serial done");
    endtask : t_serial

    initial
    begin
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        t_regs();
        t_timing();
        t_preload();
        t_serial();
        print_verdict();
    end
endmodule : cst_timing_tb
